/* inc/sbsc_pkg.sv */
// shared widths, mode layout and reset values of the burst sram core
package sbsc_pkg;

  // ******************************************************************
  // geometry
  // ******************************************************************
  localparam int ADDR_W = 19;
  localparam int DATA_W = 72;
  localparam int LANES = 8;
  localparam int LANE_W = 9;
  localparam int BURST_W = 2;
  localparam int DEPTH = 524288;
  localparam int HI_W = ADDR_W - BURST_W;

  // ******************************************************************
  // synchronised asynchronous and static mode inputs
  // ******************************************************************
  typedef struct packed {
    logic oe;
    logic sleep;
    logic pipelined;
    logic single_desel;
    logic interleaved;
  } sbsc_mode_type;

  localparam int MODE_W = 5;

  // floating mode pins: single deselect, interleaved, pipelined
  localparam sbsc_mode_type MODE_RST = '{
    oe: 1'h0,
    sleep: 1'h0,
    pipelined: 1'h1,
    single_desel: 1'h1,
    interleaved: 1'h1
  };

  // ******************************************************************
  // synchronous command inputs, decoded active high
  // ******************************************************************
  typedef struct packed {
    logic selected;
    logic proc_strobe;
    logic ctrl_strobe;
    logic advance;
    logic byte_gate;
    logic all_write;
    logic [LANES-1:0] lane_we;
  } sbsc_cmd_type;

  localparam logic [BURST_W-1:0] COUNT_RST = 2'h0;
  localparam logic [BURST_W-1:0] COUNT_STEP = 2'h1;
  localparam logic [HI_W-1:0] BASE_RST = 17'h00000;
  localparam logic [DATA_W-1:0] DATA_RST = 72'h0;

endpackage

/* logic/sbsc_sync3.sv */
// three-stage synchroniser that accepts a change once two stages agree
`timescale 1ns/100ps
`default_nettype none

module sbsc_sync3 #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] out_reg;
  logic [W-1:0] agree;
  logic [W-1:0] out_next;

  // s1 feeds only s2; a one-cycle glitch never makes s2 and s3 agree
  assign agree = ~(s2_reg ^ s3_reg);
  assign out_next = (out_reg & ~agree) | (s3_reg & agree);

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      s1_reg <= RST_VAL;
      s2_reg <= RST_VAL;
      s3_reg <= RST_VAL;
      out_reg <= RST_VAL;
    end else begin
      s1_reg <= i_async;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      out_reg <= out_next;
    end
  end

  assign o_sync = out_reg;

endmodule

`default_nettype wire

/* logic/sbsc_burst_counter.sv */
// two-bit burst counter giving the low address bits of each access
`timescale 1ns/100ps
`default_nettype none

module sbsc_burst_counter (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_load,
  input wire logic i_advance,
  input wire logic [sbsc_pkg::BURST_W-1:0] i_start,
  input wire logic i_interleaved,
  output logic [sbsc_pkg::BURST_W-1:0] o_lsb
);

  logic [sbsc_pkg::BURST_W-1:0] start_reg;
  logic [sbsc_pkg::BURST_W-1:0] start_next;
  logic [sbsc_pkg::BURST_W-1:0] count_reg;
  logic [sbsc_pkg::BURST_W-1:0] count_next;

  function automatic logic [sbsc_pkg::BURST_W-1:0] burst_lsb(
    input logic [sbsc_pkg::BURST_W-1:0] start,
    input logic [sbsc_pkg::BURST_W-1:0] count,
    input logic interleaved
  );
    // interleave is a xor, linear a modulo-four sum
    burst_lsb = interleaved ? (start ^ count) : (start + count);
  endfunction

  assign start_next = i_load ? i_start : start_reg;
  // the two-bit sum wraps to the start after the fourth address
  assign count_next = i_load ? sbsc_pkg::COUNT_RST :
    (i_advance ? count_reg + sbsc_pkg::COUNT_STEP : count_reg);

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      start_reg <= sbsc_pkg::COUNT_RST;
      count_reg <= sbsc_pkg::COUNT_RST;
    end else begin
      start_reg <= start_next;
      count_reg <= count_next;
    end
  end

  assign o_lsb = burst_lsb(start_next, count_next, i_interleaved);

endmodule

`default_nettype wire

/* logic/sbsc_core.sv */
// control, storage and read path of the synchronous burst sram
//
// Function
// - controls sampled only on rising clock
// - output enable and sleep resynchronised, act cycles later
// - either address strobe starts burst, loads address
// - burst steps only while advance asserted
// - counter is two bits on lsbs
// - order chosen by burst order select
// - new external address accepted every cycle
// - bypass select low skips output register
// - bypass select high uses output register
// - single deselect releases after deselect edge
// - dual deselect releases after second edge when pipelined
// - deselect timing chosen by static select
// - floating modes: single, interleaved, pipelined
// - byte gate writes only enabled lanes
// - all lanes write overrides lane controls
// - write timed internally, no pulse needed
// - 512K words, 72 bits, eight lanes
// - order select low linear, high interleaved
// - counter wraps after fourth address
// - selected when middle high, others low
// - sleep high gives standby, low normal
`timescale 1ns/100ps
`default_nettype none

module sbsc_core (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic [sbsc_pkg::ADDR_W-1:0] i_addr,
  input wire logic [sbsc_pkg::DATA_W-1:0] i_dq,
  input wire logic i_chip_select_low_first_n,
  input wire logic i_chip_select_high,
  input wire logic i_chip_select_low_second_n,
  input wire logic i_processor_address_strobe_n,
  input wire logic i_controller_address_strobe_n,
  input wire logic i_burst_advance_n,
  input wire logic i_byte_write_gate_n,
  input wire logic [sbsc_pkg::LANES-1:0] i_lane_write_enable_n,
  input wire logic i_all_lanes_write_n,
  input wire logic i_output_enable_n,
  input wire logic i_sleep_request,
  input wire logic i_output_bypass_select,
  input wire logic i_deselect_timing_select,
  input wire logic i_burst_order_select,
  output logic [sbsc_pkg::DATA_W-1:0] o_dq,
  output logic o_dq_oe,
  output logic o_standby
);

  // ******************************************************************
  // declarations
  // ******************************************************************
  sbsc_pkg::sbsc_cmd_type cmd;
  sbsc_pkg::sbsc_mode_type mode;
  logic [sbsc_pkg::MODE_W-1:0] mode_raw;
  logic [sbsc_pkg::MODE_W-1:0] mode_sync;

  logic active;
  logic strobe;
  logic start_now;
  logic desel_now;
  logic cont_now;
  logic step_now;
  logic wr_allowed;
  logic write_now;
  logic read_now;
  logic [sbsc_pkg::LANES-1:0] lane_mask;
  logic [sbsc_pkg::LANES-1:0] wr_lanes;

  logic session_reg;
  logic session_next;
  logic [sbsc_pkg::HI_W-1:0] base_hi_reg;
  logic [sbsc_pkg::HI_W-1:0] base_hi_next;
  logic [sbsc_pkg::HI_W-1:0] addr_hi;
  logic [sbsc_pkg::BURST_W-1:0] addr_lsb;
  logic [sbsc_pkg::ADDR_W-1:0] eff_addr;

  logic [sbsc_pkg::DATA_W-1:0] mem_array [0:sbsc_pkg::DEPTH-1];
  logic [sbsc_pkg::DATA_W-1:0] old_word;
  logic [sbsc_pkg::DATA_W-1:0] wr_word;

  logic [sbsc_pkg::DATA_W-1:0] stage_reg;
  logic [sbsc_pkg::DATA_W-1:0] stage_next;
  logic rd_v1_reg;
  logic src_valid;
  logic [sbsc_pkg::DATA_W-1:0] dq_src;
  logic [sbsc_pkg::DATA_W-1:0] dq_reg;
  logic [sbsc_pkg::DATA_W-1:0] dq_next;
  logic oe_reg;
  logic oe_next;
  logic cut_now;
  logic standby_reg;

  // ******************************************************************
  // asynchronous and mode pins
  // ******************************************************************
  // these pins are not tied to the sram clock, so they are
  // resynchronised; the price is a few cycles of response latency
  assign mode_raw = {
    ~i_output_enable_n,
    i_sleep_request,
    i_output_bypass_select,
    i_deselect_timing_select,
    i_burst_order_select
  };

  sbsc_sync3 #(
    .W(sbsc_pkg::MODE_W),
    .RST_VAL(sbsc_pkg::MODE_RST)
  ) u_mode_sync (
    .i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst),
    .i_async(mode_raw),
    .o_sync(mode_sync)
  );

  // high levels map to pipelined, single deselect and interleaved
  assign mode = sbsc_pkg::sbsc_mode_type'(mode_sync);

  // ******************************************************************
  // command decode
  // ******************************************************************
  // all of these come from host logic on the same clock edge
  assign cmd.selected = i_chip_select_high &
    ~i_chip_select_low_first_n &
    ~i_chip_select_low_second_n;
  assign cmd.proc_strobe = ~i_processor_address_strobe_n;
  assign cmd.ctrl_strobe = ~i_controller_address_strobe_n;
  assign cmd.advance = ~i_burst_advance_n;
  assign cmd.byte_gate = ~i_byte_write_gate_n;
  assign cmd.all_write = ~i_all_lanes_write_n;
  assign cmd.lane_we = ~i_lane_write_enable_n;

  // standby ignores every command until sleep is released
  assign active = ~mode.sleep;

  assign strobe = (cmd.proc_strobe | cmd.ctrl_strobe) & active;
  assign start_now = strobe & cmd.selected;
  assign desel_now = strobe & ~cmd.selected;
  assign cont_now = ~strobe & session_reg & active;
  assign step_now = cont_now & cmd.advance;

  // ******************************************************************
  // write lane decode
  // ******************************************************************
  assign lane_mask = cmd.all_write ? {sbsc_pkg::LANES{1'h1}} :
    (cmd.byte_gate ? cmd.lane_we : {sbsc_pkg::LANES{1'h0}});

  // a processor strobe always opens with a read, which lets a
  // cache controller issue it before the write controls settle
  assign wr_allowed = (start_now & ~cmd.proc_strobe) | cont_now;
  assign wr_lanes = wr_allowed ? lane_mask : {sbsc_pkg::LANES{1'h0}};
  assign write_now = |wr_lanes;
  assign read_now = (start_now | cont_now) & ~write_now;

  // ******************************************************************
  // burst address
  // ******************************************************************
  sbsc_burst_counter u_burst (
    .i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst),
    .i_load(start_now),
    .i_advance(step_now),
    .i_start(i_addr[sbsc_pkg::BURST_W-1:0]),
    .i_interleaved(mode.interleaved),
    .o_lsb(addr_lsb)
  );

  assign base_hi_next = start_now ?
    i_addr[sbsc_pkg::ADDR_W-1:sbsc_pkg::BURST_W] : base_hi_reg;
  assign addr_hi = base_hi_next;
  assign eff_addr = {addr_hi, addr_lsb};

  assign session_next = start_now ? 1'h1 :
    (desel_now ? 1'h0 : session_reg);

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      session_reg <= 1'h0;
      base_hi_reg <= sbsc_pkg::BASE_RST;
    end else begin
      session_reg <= session_next;
      base_hi_reg <= base_hi_next;
    end
  end

  // ******************************************************************
  // storage array
  // ******************************************************************
  assign old_word = mem_array[eff_addr];

  // merge per lane so the array keeps a single writer
  for (genvar g = 0; g < sbsc_pkg::LANES; g++) begin : g_lane
    assign wr_word[g*sbsc_pkg::LANE_W +: sbsc_pkg::LANE_W] = wr_lanes[g] ?
      i_dq[g*sbsc_pkg::LANE_W +: sbsc_pkg::LANE_W] :
      old_word[g*sbsc_pkg::LANE_W +: sbsc_pkg::LANE_W];
  end

  // the whole write completes on the edge that takes the command
  always_ff @(posedge i_clk_sys) begin
    if (write_now) begin
      mem_array[eff_addr] <= wr_word;
    end
  end

  // ******************************************************************
  // read path
  // ******************************************************************
  // the stage register loads on every read; in flow mode it is skipped
  assign stage_next = read_now ? old_word : stage_reg;

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      stage_reg <= sbsc_pkg::DATA_RST;
      rd_v1_reg <= 1'h0;
    end else begin
      stage_reg <= stage_next;
      rd_v1_reg <= read_now;
    end
  end

  // pipelined data leaves one edge after flow-through data
  assign src_valid = mode.pipelined ? rd_v1_reg : read_now;
  assign dq_src = mode.pipelined ? stage_reg : old_word;
  assign dq_next = src_valid ? dq_src : dq_reg;

  // ******************************************************************
  // output release
  // ******************************************************************
  // single deselect cuts a pipelined read still in flight on the
  // deselect edge; dual deselect lets it finish one more cycle
  assign cut_now = mode.single_desel & desel_now;
  assign oe_next = src_valid & mode.oe & ~mode.sleep & ~cut_now;

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      dq_reg <= sbsc_pkg::DATA_RST;
      oe_reg <= 1'h0;
      standby_reg <= 1'h0;
    end else begin
      dq_reg <= dq_next;
      oe_reg <= oe_next;
      standby_reg <= mode.sleep;
    end
  end

  assign o_dq = dq_reg;
  assign o_dq_oe = oe_reg;
  assign o_standby = standby_reg;

endmodule

`default_nettype wire

/* verif/sbsc_core_assertions.sv */
// concurrent checks on the pins of the burst sram core
`timescale 1ns/100ps
`default_nettype none

module sbsc_core_assertions (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_chip_select_low_first_n,
  input wire logic i_chip_select_high,
  input wire logic i_chip_select_low_second_n,
  input wire logic i_processor_address_strobe_n,
  input wire logic i_controller_address_strobe_n,
  input wire logic i_byte_write_gate_n,
  input wire logic [sbsc_pkg::LANES-1:0] i_lane_write_enable_n,
  input wire logic i_all_lanes_write_n,
  input wire logic i_output_enable_n,
  input wire logic i_sleep_request,
  input wire logic i_output_bypass_select,
  input wire logic i_deselect_timing_select,
  input wire logic o_dq_oe,
  input wire logic o_standby
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);

  // ******************************************************************
  // command decode
  // ******************************************************************
  wire logic sel = i_chip_select_high & ~i_chip_select_low_first_n
    & ~i_chip_select_low_second_n;
  wire logic strb = ~i_processor_address_strobe_n
    | ~i_controller_address_strobe_n;
  wire logic desel = strb & ~sel;
  wire logic wmask = ~i_all_lanes_write_n
    | (~i_byte_write_gate_n & ~&i_lane_write_enable_n);
  wire logic rd = sel & (~i_processor_address_strobe_n | (strb & ~wmask));
  // mode pins pass a synchroniser, so only long-steady levels are judged
  wire logic run = ~i_output_enable_n & ~i_sleep_request;
  wire logic pipe = run & i_output_bypass_select & i_deselect_timing_select;
  wire logic flow = run & ~i_output_bypass_select & i_deselect_timing_select;
  wire logic dual = run & i_output_bypass_select & ~i_deselect_timing_select;

  // ******************************************************************
  // properties
  // ******************************************************************
  property p_sby_oe;
    o_standby |-> !o_dq_oe;
  endproperty
  a_sby_oe: assert property (p_sby_oe)
    else $error("pins driven in standby");
  property p_sleep_on;
    i_sleep_request[*6] |=> o_standby;
  endproperty
  a_sleep_on: assert property (p_sleep_on)
    else $error("standby not entered");
  property p_sleep_off;
    !i_sleep_request[*6] |=> !o_standby;
  endproperty
  a_sleep_off: assert property (p_sleep_off)
    else $error("standby without request");
  property p_oe_off;
    i_output_enable_n[*6] |=> !o_dq_oe;
  endproperty
  a_oe_off: assert property (p_oe_off)
    else $error("pins driven with output enable off");
  property p_scd;
    (i_deselect_timing_select & ~i_sleep_request)[*6] ##0 desel |=> !o_dq_oe;
  endproperty
  a_scd: assert property (p_scd)
    else $error("single deselect did not release");
  property p_dcd;
    dual[*6] ##0 desel ##1 (dual & !strb) |=> !o_dq_oe;
  endproperty
  a_dcd: assert property (p_dcd)
    else $error("dual deselect did not release");
  property p_pipe;
    pipe[*6] ##0 desel ##1 (pipe & rd) ##1 (pipe & !desel)
      |-> !o_dq_oe ##1 o_dq_oe;
  endproperty
  a_pipe: assert property (p_pipe)
    else $error("pipelined read latency wrong");
  property p_flow;
    flow[*6] ##0 desel ##1 (flow & rd) |=> o_dq_oe;
  endproperty
  a_flow: assert property (p_flow)
    else $error("flow-through read latency wrong");
endmodule

`default_nettype wire

/* verif/sbsc_host_model.sv */
// host controller model driving the burst sram command pins
`timescale 1ns/100ps
`default_nettype none

module sbsc_host_model (
  input wire logic i_clk_sys,
  output logic [2:0] o_cs,
  output var sbsc_pkg::sbsc_cmd_type o_cmd,
  output logic [sbsc_pkg::ADDR_W-1:0] o_addr,
  output logic [sbsc_pkg::DATA_W-1:0] o_dq,
  output var sbsc_pkg::sbsc_mode_type o_mode
);
  initial begin
    o_cs = 3'h5;
    o_cmd = '0;
    o_addr = '0;
    o_dq = '0;
    o_mode = sbsc_pkg::MODE_RST;
  end

  // o_cs is {low first, high, low second}; all change just after an edge
  task automatic step(input logic [2:0] cs, input sbsc_pkg::sbsc_cmd_type c,
      input logic [sbsc_pkg::ADDR_W-1:0] a,
      input logic [sbsc_pkg::DATA_W-1:0] d);
    @(posedge i_clk_sys);
    o_cs <= cs;
    o_cmd <= c;
    // unused lines toggle so that a stale value never looks valid
    o_addr <= (c.proc_strobe | c.ctrl_strobe) ? a : ~o_addr;
    o_dq <= (c.all_write | c.byte_gate) ? d : ~o_dq;
  endtask

  task automatic set_mode(input sbsc_pkg::sbsc_mode_type m);
    @(posedge i_clk_sys);
    o_mode <= m;
    repeat (6) @(posedge i_clk_sys);
    #1;
  endtask
endmodule

`default_nettype wire

/* verif/tb_sbsc_core.sv */
// bench for the burst sram core: bursts, lane writes, deselect, sleep
`timescale 1ns/100ps
`default_nettype none

module tb_sbsc_core;
  localparam logic [2:0] SEL = 3'h2;
  localparam logic [2:0] DES = 3'h5;
  localparam sbsc_pkg::sbsc_cmd_type C_IDLE = 14'h0000;
  localparam sbsc_pkg::sbsc_cmd_type C_RDP = 14'h1000;
  localparam sbsc_pkg::sbsc_cmd_type C_RDC = 14'h0800;
  localparam sbsc_pkg::sbsc_cmd_type C_ADV = 14'h0400;
  localparam sbsc_pkg::sbsc_cmd_type C_ALL = 14'h09F0;
  localparam sbsc_pkg::sbsc_cmd_type C_LANE = 14'h0A0F;
  localparam sbsc_pkg::sbsc_cmd_type C_NOGATE = 14'h080F;
  localparam logic [18:0] W0 = 19'h00100;
  localparam logic [18:0] W2 = 19'h00104;
  localparam logic [71:0] LOW4 = {36'h0, 36'hFFFFFFFFF};
  localparam sbsc_pkg::sbsc_mode_type MODES [4] = '{5'h17, 5'h16, 5'h12, 5'h15};
  logic i_clk_sys;
  logic i_sys_rst;
  logic [2:0] cs;
  sbsc_pkg::sbsc_cmd_type cmd;
  sbsc_pkg::sbsc_mode_type mode;
  logic [18:0] addr;
  logic [71:0] wdat;
  logic [71:0] o_dq;
  logic o_dq_oe;
  logic o_standby;
  int err_count;
  int checked;

  sbsc_host_model sbsc_host_model_i (.i_clk_sys(i_clk_sys), .o_cs(cs),
    .o_cmd(cmd), .o_addr(addr), .o_dq(wdat), .o_mode(mode));

  sbsc_core sbsc_core_i (
    .i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst),
    .i_addr(addr),
    .i_dq(wdat),
    .i_chip_select_low_first_n(cs[2]),
    .i_chip_select_high(cs[1]),
    .i_chip_select_low_second_n(cs[0]),
    .i_processor_address_strobe_n(~cmd.proc_strobe),
    .i_controller_address_strobe_n(~cmd.ctrl_strobe),
    .i_burst_advance_n(~cmd.advance),
    .i_byte_write_gate_n(~cmd.byte_gate),
    .i_lane_write_enable_n(~cmd.lane_we),
    .i_all_lanes_write_n(~cmd.all_write),
    .i_output_enable_n(~mode.oe),
    .i_sleep_request(mode.sleep),
    .i_output_bypass_select(mode.pipelined),
    .i_deselect_timing_select(mode.single_desel),
    .i_burst_order_select(mode.interleaved),
    .o_dq(o_dq),
    .o_dq_oe(o_dq_oe),
    .o_standby(o_standby)
  );

  // ******************************************************************
  // helpers
  // ******************************************************************
  function automatic logic [71:0] pat(input logic [18:0] a);
    return {4{a[17:0]}};
  endfunction

  task automatic cmp(input string what, input logic [71:0] exp,
      input logic [71:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // outputs seen after return belong to the command issued one call before, two calls before when pipelined
  task automatic go(input logic [2:0] c, input sbsc_pkg::sbsc_cmd_type k,
      input logic [18:0] a);
    sbsc_host_model_i.step(c, k, a, pat(a));
    #1;
  endtask

  task automatic burst(input logic [18:0] a, input sbsc_pkg::sbsc_mode_type md);
    int lat;
    int j;
    logic [1:0] lsb;
    lat = md.pipelined ? 2 : 1;
    go(DES, C_RDC, '0);
    for (int i = 0; i < 6 + lat; i++) begin
      go(SEL, i == 0 ? C_RDP : (i < 5 ? C_ADV : C_IDLE), a);
      j = (i - lat > 4) ? 4 : i - lat;
      lsb = md.interleaved ? a[1:0] ^ 2'(j) : a[1:0] + 2'(j);
      cmp("oe", 72'(i >= lat), 72'(o_dq_oe));
      if (i >= lat) cmp("burst", pat({a[18:2], lsb}), o_dq);
    end
    $display("burst done");
  endtask

  task automatic desel(input logic dual);
    go(DES, C_RDC, '0);
    go(DES, C_IDLE, '0);
    cmp("oe desel", 72'(dual), 72'(o_dq_oe));
    go(DES, C_IDLE, '0);
    cmp("oe off", '0, 72'(o_dq_oe));
    $display("deselect done");
  endtask

  task automatic rdw(input logic [71:0] exp);
    go(SEL, C_RDP, W2);
    go(DES, C_RDC, '0);
    go(DES, C_IDLE, '0);
    cmp("word", exp, o_dq);
    $display("word read done");
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ******************************************************************
  // clock, watchdog and test sequence
  // ******************************************************************
  initial begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end

  initial begin
    repeat (3000) @(posedge i_clk_sys);
    err_count++;
    end_of_test();
  end

  initial begin
    i_sys_rst = 1'b1;
    err_count = 0;
    checked = 0;
    repeat (12) @(posedge i_clk_sys);
    i_sys_rst <= 1'b0;
    @(posedge i_clk_sys);
    #1;
    cmp("standby", '0, 72'(o_standby));
    for (int i = 0; i < 4; i++) go(SEL, C_ALL, {W0[18:2], 2'(i)});
    go(SEL, C_ALL, W2);
    sbsc_host_model_i.step(SEL, C_LANE, W2, ~pat(W2));
    sbsc_host_model_i.step(SEL, C_NOGATE, W2, '0);
    go(DES, C_RDC, '0);
    $display("writes done");
    for (int m = 0; m < 4; m++) begin
      sbsc_host_model_i.set_mode(MODES[m]);
      burst(W0 | 19'h00001, MODES[m]);
      desel(~MODES[m].single_desel);
    end
    sbsc_host_model_i.set_mode(5'h17);
    rdw(pat(W2) ^ LOW4);
    sbsc_host_model_i.set_mode(5'h1F);
    cmp("standby", 72'h1, 72'(o_standby));
    cmp("oe sleep", '0, 72'(o_dq_oe));
    sbsc_host_model_i.step(SEL, C_ALL, W2, '0);
    go(DES, C_RDC, '0);
    sbsc_host_model_i.set_mode(5'h17);
    rdw(pat(W2) ^ LOW4);
    end_of_test();
  end
endmodule

bind sbsc_core sbsc_core_assertions sbsc_core_assertions_i (.*);

`default_nettype wire
